/* File: logic/clock_divider.sv */
// divide-by-eight generator of the two local clock phases
`timescale 1ns/100ps
`default_nettype none

module clock_divider
    import reset_boot_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    output logic      phase1,
    output logic      phase2,
    output logic      phase1Fall
);

    // ==========================================================
    // phase counter
    logic [PHASE_WIDTH-1:0] phaseCount_reg;
    logic [PHASE_WIDTH-1:0] phaseCount_next;
    logic                   phase1_reg;
    logic                   phase1_next;
    logic                   phase2_reg;
    logic                   phase2_next;

    always_comb begin
        phaseCount_next = phaseCount_reg + 3'h1;              // [RULE8]
        phase1_next     = (phaseCount_next <= PHASE1_LAST_HIGH);
        phase2_next     = (phaseCount_next >= PHASE2_FIRST_HIGH) &&
                          (phaseCount_next <= PHASE2_LAST_HIGH);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phaseCount_reg <= PHASE_RESET;
            phase1_reg     <= 1'h1;
            phase2_reg     <= 1'h0;
        end else begin
            phaseCount_reg <= phaseCount_next;
            phase1_reg     <= phase1_next;
            phase2_reg     <= phase2_next;
        end
    end

    assign phase1     = phase1_reg;
    assign phase2     = phase2_reg;
    // high in the cycle whose closing edge drops phase 1
    assign phase1Fall = (phaseCount_reg == PHASE1_LAST_HIGH);

    // ==========================================================
    // checks
    phase1_shape_a: assert property ( // [RULE8]
        @(posedge clk) disable iff (!reset_n)
        $rose(phase1) |=> phase1[*3] ##1 !phase1[*4] ##1 phase1)
        else $error("phase 1 is not a divide-by-eight square wave");

    phase2_lag_a: assert property ( // [RULE8]
        @(posedge clk) disable iff (!reset_n)
        $rose(phase1) |-> ##2 $rose(phase2))
        else $error("phase 2 does not lag phase 1 by a quarter");

endmodule

`default_nettype wire

/* File: logic/reset_boot_pkg.sv */
// constants and types shared by the reset, boot-mode and clock divider logic
package reset_boot_pkg;

    // ==========================================================
    // clock divider
    localparam int          DIVIDE_RATIO      = 8;
    localparam int          PHASE_WIDTH       = 3;
    localparam logic [2:0]  PHASE1_LAST_HIGH  = 3'h3;
    localparam logic [2:0]  PHASE2_FIRST_HIGH = 3'h2;
    localparam logic [2:0]  PHASE2_LAST_HIGH  = 3'h5;
    localparam logic [2:0]  PHASE_RESET       = 3'h0;

    // ==========================================================
    // post-reset sequence
    localparam int          PERIOD_WIDTH      = 5;
    localparam logic [4:0]  IGNORE_PERIODS    = 5'h11;
    localparam int          REFRESH_WIDTH     = 4;
    localparam logic [3:0]  REFRESH_CYCLES    = 4'h8;
    localparam logic        HALT_RESET        = 1'h1;

    typedef enum logic [1:0] {
        HELD,
        IGNORE,
        RUN
    } seq_state_t;

endpackage

/* File: logic/reset_boot_sequencer.sv */
// reset entry and exit, start-up mode selection and local clock phases
//
// How it works
// RULE1: reset and host select each pass two flip-flops before use.
// RULE2: synced levels sampled and edges detected at phase 1 falling edge.
// RULE3: select low at reset release clears the halt flag.
// RULE4: select high at reset release sets the halt flag.
// RULE5: host select ignored for 17 local periods after release edge.
// RULE6: eight row-only refresh cycles run before host select is honoured.
// RULE7: host holds reset low at least 160 quarter periods less 40 ns.
// RULE8: input clock divided by eight into two local clock phases.
`timescale 1ns/100ps
`default_nettype none

module reset_boot_sequencer
    import reset_boot_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic hostReset_n,
    input  wire logic hostSelect_n,
    output logic      localClockPhase1,
    output logic      localClockPhase2,
    output logic      haltFlag,
    output logic      deviceInReset,
    output logic      refreshStrobe,
    output logic      refreshActive,
    output logic      hostSelectValid
);

    // ==========================================================
    // local clock phases
    logic phase1Fall;

    clock_divider u_clock_divider (
        .clk        (clk),
        .reset_n    (reset_n),
        .phase1     (localClockPhase1),
        .phase2     (localClockPhase2),
        .phase1Fall (phase1Fall)
    );

    // ==========================================================
    // input synchronisers
    logic resetSync1_reg;
    logic resetSync2_reg;
    logic selectSync1_reg;
    logic selectSync2_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resetSync1_reg  <= 1'h0;
            resetSync2_reg  <= 1'h0;
            selectSync1_reg <= 1'h1;
            selectSync2_reg <= 1'h1;
        end else begin
            resetSync1_reg  <= hostReset_n;                   // [RULE1]
            resetSync2_reg  <= resetSync1_reg;                // [RULE1]
            selectSync1_reg <= hostSelect_n;                  // [RULE1]
            selectSync2_reg <= selectSync1_reg;               // [RULE1]
        end
    end

    // ==========================================================
    // sampling at the phase 1 falling edge
    logic resetSample_reg;
    logic resetSample_next;
    logic selectSample_reg;
    logic selectSample_next;
    logic releaseDetected;
    logic entryDetected;

    always_comb begin
        resetSample_next  = resetSample_reg;
        selectSample_next = selectSample_reg;
        if (phase1Fall) begin
            resetSample_next  = resetSync2_reg;               // [RULE2]
            selectSample_next = selectSync2_reg;              // [RULE2]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resetSample_reg  <= 1'h0;
            selectSample_reg <= 1'h1;
        end else begin
            resetSample_reg  <= resetSample_next;
            selectSample_reg <= selectSample_next;
        end
    end

    // release transition and low reset level seen at this phase 1 falling edge
    assign releaseDetected = phase1Fall && !resetSample_reg &&
                             resetSync2_reg;                  // [RULE2]
    assign entryDetected   = phase1Fall && !resetSync2_reg;   // [RULE2]

    // ==========================================================
    // post-reset sequence
    seq_state_t                state_reg;
    seq_state_t                state_next;
    logic [PERIOD_WIDTH-1:0]   periodCount_reg;
    logic [PERIOD_WIDTH-1:0]   periodCount_next;
    logic [REFRESH_WIDTH-1:0]  refreshCount_reg;
    logic [REFRESH_WIDTH-1:0]  refreshCount_next;
    logic                      halt_reg;
    logic                      halt_next;
    logic                      refresh_reg;
    logic                      refresh_next;

    always_comb begin
        state_next        = state_reg;
        periodCount_next  = periodCount_reg;
        refreshCount_next = refreshCount_reg;
        halt_next         = halt_reg;
        refresh_next      = 1'h0;
        if (entryDetected) begin
            state_next = HELD;
        end else begin
            unique case (state_reg)
                HELD: begin
                    if (releaseDetected) begin
                        state_next        = IGNORE;
                        periodCount_next  = '0;
                        refreshCount_next = '0;
                        // boot mode taken from select at the release edge
                        halt_next = selectSync2_reg;      // [RULE3] [RULE4]
                    end
                end
                IGNORE: begin
                    if (phase1Fall) begin
                        periodCount_next = periodCount_reg + 5'h01; // [RULE5]
                        if (refreshCount_reg < REFRESH_CYCLES) begin
                            refresh_next      = 1'h1;             // [RULE6]
                            refreshCount_next = refreshCount_reg + 4'h1;
                        end
                        if (periodCount_next == IGNORE_PERIODS &&
                            refreshCount_next == REFRESH_CYCLES) begin
                            state_next = RUN;             // [RULE5] [RULE6]
                        end
                    end
                end
                RUN: begin
                    state_next = RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg        <= HELD;
            periodCount_reg  <= '0;
            refreshCount_reg <= '0;
            halt_reg         <= HALT_RESET;
            refresh_reg      <= 1'h0;
        end else begin
            state_reg        <= state_next;
            periodCount_reg  <= periodCount_next;
            refreshCount_reg <= refreshCount_next;
            halt_reg         <= halt_next;
            refresh_reg      <= refresh_next;
        end
    end

    // ==========================================================
    // outputs
    assign haltFlag        = halt_reg;
    assign deviceInReset   = (state_reg == HELD);
    assign refreshStrobe   = refresh_reg;
    assign refreshActive   = (state_reg == IGNORE) &&
                             (refreshCount_reg < REFRESH_CYCLES);
    // select only counts once the ignore window and refreshes are over
    assign hostSelectValid = (state_reg == RUN) &&
                             !selectSample_reg;               // [RULE5] [RULE6]

    // ==========================================================
    // checks
    sequence release_low_s;
        releaseDetected && !selectSync2_reg;
    endsequence

    sequence release_high_s;
        releaseDetected && selectSync2_reg;
    endsequence

    reset_sync_a: assert property ( // [RULE1]
        @(posedge clk) disable iff (!reset_n)
        $past(reset_n, 2) |-> resetSync2_reg == $past(hostReset_n, 2))
        else $error("reset level not delayed by two flip-flops");

    sample_edge_a: assert property ( // [RULE2]
        @(posedge clk) disable iff (!reset_n)
        ($changed(resetSample_reg) || $changed(selectSample_reg))
        |-> $past(phase1Fall))
        else $error("sample changed away from phase 1 falling edge");

    boot_clear_a: assert property ( // [RULE3]
        @(posedge clk) disable iff (!reset_n)
        release_low_s |=> !haltFlag && state_reg == IGNORE)
        else $error("halt flag not cleared for self-bootstrap");

    boot_halt_a: assert property ( // [RULE4]
        @(posedge clk) disable iff (!reset_n)
        release_high_s |=> haltFlag && state_reg == IGNORE)
        else $error("halt flag not set for halted start");

    select_ignored_a: assert property ( // [RULE5]
        @(posedge clk) disable iff (!reset_n)
        releaseDetected |=> !hostSelectValid[*8])
        else $error("host select honoured inside ignore window");

    // clock cycles spent in the ignore window, kept for the checks only
    logic [7:0] windowClocks_reg;
    logic [7:0] windowClocks_next;

    always_comb begin
        windowClocks_next = windowClocks_reg;
        if (releaseDetected) begin
            windowClocks_next = 8'h00;
        end else if (state_reg == IGNORE) begin
            windowClocks_next = windowClocks_reg + 8'h01;     // [RULE5]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            windowClocks_reg <= 8'h00;
        end else begin
            windowClocks_reg <= windowClocks_next;
        end
    end

    ignore_length_a: assert property ( // [RULE5]
        @(posedge clk) disable iff (!reset_n)
        $rose(state_reg == RUN) |-> periodCount_reg == IGNORE_PERIODS &&
            windowClocks_reg == 8'(IGNORE_PERIODS * DIVIDE_RATIO))
        else $error("ignore window not seventeen periods");

    first_refresh_a: assert property ( // [RULE6]
        @(posedge clk) disable iff (!reset_n)
        releaseDetected ##1 !entryDetected[*8] |=> refreshStrobe)
        else $error("first refresh not at next phase 1 fall");

    refresh_done_a: assert property ( // [RULE6]
        @(posedge clk) disable iff (!reset_n)
        hostSelectValid |-> refreshCount_reg == REFRESH_CYCLES)
        else $error("select honoured before eight refreshes");

endmodule

`default_nettype wire

/* File: testbench/host_model.sv */
// behavioural host driving the device reset and select pins
`timescale 1ns/100ps
`default_nettype none

module host_model #(
    parameter int HOLD_LOW = 330
) (
    input  wire logic clk,
    input  wire logic wantReset,
    input  wire logic wantSel_n,
    output var logic  hostReset_n,
    output var logic  hostSelect_n
);
    int lowCount;

    initial begin
        hostReset_n  = 1'h1;
        hostSelect_n = 1'h1;
        lowCount     = 0;
    end

    // ==========
    // pins change just after the clock edge
    always @(posedge clk) begin
        hostSelect_n <= wantSel_n;
        if (wantReset) begin
            hostReset_n <= 1'h0;
            lowCount    <= 0;
        end else if (lowCount < HOLD_LOW) begin
            lowCount <= lowCount + 1;
        end else begin
            hostReset_n <= 1'h1;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb_reset_boot_mode_and_clock_divider.sv */
// self-checking bench of reset, boot mode and clock phases
`timescale 1ns/100ps
`default_nettype none

module tb_reset_boot_mode_and_clock_divider
    import reset_boot_pkg::*;
;
    typedef struct {
        logic sel_n;
        logic halt;
    } row_t;

    logic clk, reset_n, wantReset, wantSel_n, hostReset_n, hostSelect_n;
    logic ph1, ph2, haltFlag, inReset, refStb, refAct, selValid;
    logic p1 [16];
    logic p2 [16];
    row_t rows [2];
    int   err_count;
    int   tests_run;
    int   n;

    host_model u_host_model (.clk(clk), .wantReset(wantReset),
        .wantSel_n(wantSel_n), .hostReset_n(hostReset_n),
        .hostSelect_n(hostSelect_n));

    reset_boot_sequencer u_reset_boot_sequencer (.clk(clk),
        .reset_n(reset_n), .hostReset_n(hostReset_n),
        .hostSelect_n(hostSelect_n), .localClockPhase1(ph1),
        .localClockPhase2(ph2), .haltFlag(haltFlag),
        .deviceInReset(inReset), .refreshStrobe(refStb),
        .refreshActive(refAct), .hostSelectValid(selValid));

    // ==========
    // shared tasks
    task automatic check(input logic [8:0] got, input logic [8:0] exp,
                         input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wait_level(input logic v);
        int k;
        k = 0;
        @(negedge clk);
        while (inReset !== v && k < 400) begin
            @(negedge clk);
            k++;
        end
        check(inReset, v, "reset state");
    endtask

    task automatic run_row(input row_t r);
        int first;
        int valid;
        int act;
        @(posedge clk);
        wantReset <= 1'h1;
        wantSel_n <= r.sel_n;
        wait_level(1'h1);
        @(posedge clk);
        wantReset <= 1'h0;
        wait_level(1'h0);
        check(haltFlag, r.halt, "halt flag");
        @(posedge clk);
        wantSel_n <= 1'h0;
        n = 0;
        first = -1;
        valid = -1;
        act = 0;
        for (int i = 0; i < 200; i++) begin
            @(negedge clk);
            if (refStb === 1'h1 && first < 0) first = i;
            if (refStb === 1'h1) n++;
            if (selValid === 1'h1 && valid < 0) valid = i;
            if (refAct === 1'h1) act++;
        end
        check(9'(n), 9'(REFRESH_CYCLES), "refresh count");
        check(9'(first), 9'(DIVIDE_RATIO - 1), "refresh start");
        first = REFRESH_CYCLES * DIVIDE_RATIO - 1;
        check(9'(act), 9'(first), "refresh busy");
        first = IGNORE_PERIODS * DIVIDE_RATIO - 1;
        check(9'(valid), 9'(first), "select honoured");
    endtask

    // ==========
    // clock, watchdog and main sequence
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        test_done();
    end

    initial begin
        reset_n   = 1'h0;
        wantReset = 1'h0;
        wantSel_n = 1'h1;
        err_count = 0;
        tests_run = 0;
        rows[0]   = '{1'h1, 1'h1};
        rows[1]   = '{1'h0, 1'h0};
        repeat (5) @(posedge clk);
        @(negedge clk);
        check({ph1, ph2, haltFlag, inReset, selValid},
              9'h016, "reset out");
        @(posedge clk);
        reset_n <= 1'h1;
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            p1[i] = ph1;
            p2[i] = ph2;
        end
        for (int i = 4; i < 16; i++) begin
            check(p2[i], p1[i - 2], "phase lag");
            check(p1[i], !p1[i - 4], "phase duty");
        end
        foreach (rows[r]) begin
            run_row(rows[r]);
        end
        // reset arriving in the middle of the refresh burst
        @(posedge clk);
        wantReset <= 1'h1;
        wait_level(1'h1);
        @(posedge clk);
        wantReset <= 1'h0;
        wait_level(1'h0);
        repeat (20) @(negedge clk);
        @(posedge clk);
        wantReset <= 1'h1;
        wait_level(1'h1);
        check(haltFlag, 1'h0, "halt kept");
        n = 0;
        for (int i = 0; i < 100; i++) begin
            @(negedge clk);
            if (refStb !== 1'h0 || selValid !== 1'h0 ||
                refAct !== 1'h0) n++;
        end
        check(9'(n), 9'h000, "quiet in reset");
        test_done();
    end
endmodule
`default_nettype wire
